// ---- logic/slice_pkg.sv ----
// Shared types, register map and helpers for the logic slice
package slice_pkg;
    typedef enum logic [1:0] {
        MODE_LOGIC = 2'b00,
        MODE_RIPPLE = 2'b01,
        MODE_RAM = 2'b10,
        MODE_ROM = 2'b11
    } slice_mode_e;

    typedef enum logic [3:0] {
        OP_ADD = 4'b0000,
        OP_SUB = 4'b0001,
        OP_ADDSUB = 4'b0010,
        OP_UPCOUNT = 4'b0011,
        OP_DOWNCOUNT = 4'b0100,
        OP_MULT = 4'b0101,
        OP_GE = 4'b0110,
        OP_NE = 4'b0111,
        OP_LE = 4'b1000
    } ripple_op_e;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_LUT0 = 32'h0000_0004;
    localparam logic [31:0] ADDR_LUT1 = 32'h0000_0008;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OP_LSB = 2;
    localparam int CTRL_DUAL_BIT = 6;
    localparam int CTRL_SET0_BIT = 7;
    localparam int CTRL_SET1_BIT = 8;

    localparam int STAT_Q_LSB = 0;
    localparam int STAT_F_LSB = 2;
    localparam int STAT_CARRY_BIT = 4;
    localparam int STAT_WIDE5_BIT = 5;
    localparam int STAT_WIDER_BIT = 6;

    localparam logic [15:0] LUT_RESET = 16'h0000;
    localparam logic [1:0] Q_RESET = 2'h0;
    localparam logic [1:0] SET_RESET = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Two-bit group carry from generate and propagate terms
    function automatic logic carry_gp(input logic [1:0] gen, input logic [1:0] prop, input logic cin);
        return gen[1] | (prop[1] & gen[0]) | (prop[1] & prop[0] & cin);
    endfunction
endpackage

// ---- logic/dist_ram_16x2.sv ----
// Two lookup tables of 16 bits, one write port and two read ports
`timescale 1ns/1ps
module dist_ram_16x2
    import slice_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfgWe0,
    input wire logic cfgWe1,
    input wire logic [15:0] cfgData,
    input wire logic ramWe,
    input wire logic [3:0] waddr,
    input wire logic [1:0] wdata,
    input wire logic [3:0] raddrA,
    input wire logic [3:0] raddrB,
    output logic [1:0] readA,
    output logic [1:0] readB,
    output logic [15:0] table0,
    output logic [15:0] table1
);
    // Fabric write beats a configuration write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table0 <= LUT_RESET;
        end else if (ramWe) begin
            table0[waddr] <= wdata[0];
        end else if (cfgWe0) begin
            table0 <= cfgData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table1 <= LUT_RESET;
        end else if (ramWe) begin
            table1[waddr] <= wdata[1];
        end else if (cfgWe1) begin
            table1 <= cfgData;
        end
    end

    // Reads are asynchronous on both ports
    assign readA = {table1[raddrA], table0[raddrA]};
    assign readB = {table1[raddrB], table0[raddrB]};

    ram_write_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
        ramWe |=> {table1[$past(waddr)], table0[$past(waddr)]} == $past(wdata))
        else $error("RAM write not stored");
    ram_hold_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ramWe && !cfgWe0 |=> $stable(table0))
        else $error("Table changed without a write");
endmodule

// ---- logic/fpga_logic_slice.sv ----
// Logic slice: two tables, carry chain, wide muxes, registers, AHB-Lite setup port
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module fpga_logic_slice
    import slice_pkg::*;
#(
    parameter bit RAMLESS = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lutInA,
    input wire logic [3:0] lutInB,
    input wire logic [1:0] multipurposeIn,
    input wire logic clkEnable,
    input wire logic localSetReset,
    input wire logic carryChainIn,
    input wire logic neighbourWide5In,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [1:0] tableBypassOut,
    output logic [1:0] registerOut,
    output logic wide5MuxOut,
    output logic widerMuxOut,
    output logic carryChainOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    slice_mode_e modeR;
    ripple_op_e opR;
    logic dualR;
    logic [1:0] setValR;
    logic [1:0] registerOut_r;
    logic [1:0] qNxt;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic phaseWrite_r;
    logic [31:0] phaseAddr_r;
    logic takeReq;
    logic [31:0] readWord;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [1:0] readA;
    logic [1:0] readB;
    logic [15:0] table0;
    logic [15:0] table1;
    logic ramWe;
    logic [1:0] opA;
    logic [1:0] opB;
    logic [1:0] aEff;
    logic [1:0] bEff;
    logic [1:0] gen;
    logic [1:0] prop;
    logic isNe;
    logic [1:0] rippleSum;
    logic rippleCarry;
    logic [1:0] bypass;
    logic wide5;
    logic wider;
    logic counting;

    // Bus: zero wait states, every transfer answered OKAY
    assign takeReq = hsel && hready && htrans[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseWrite_r <= 1'b0;
            phaseAddr_r <= 32'h0000_0000;
        end else begin
            phaseWrite_r <= takeReq && hwrite && (hsize == HSIZE_WORD);
            phaseAddr_r <= takeReq ? haddr : phaseAddr_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_r <= 1'b0;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // Read data is sampled at the address phase so it stands through the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= 32'h0000_0000;
        end else if (takeReq && !hwrite) begin
            hrdata_r <= readWord;
        end
    end

    assign ctrlWord = {23'h00_0000, setValR, dualR, opR, modeR};
    assign statusWord = {25'h000_0000, wider, wide5, rippleCarry, bypass, registerOut_r};

    always_comb begin
        unique case (haddr)
            ADDR_CTRL: readWord = ctrlWord;
            ADDR_LUT0: readWord = {16'h0000, table0};
            ADDR_LUT1: readWord = {16'h0000, table1};
            ADDR_STATUS: readWord = statusWord;
            default: readWord = 32'h0000_0000;
        endcase
    end

    // Configuration word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modeR <= MODE_LOGIC;
            opR <= OP_ADD;
            dualR <= 1'b0;
            setValR <= SET_RESET;
        end else if (phaseWrite_r && phaseAddr_r == ADDR_CTRL) begin
            // RAM-less variant keeps its previous mode on a RAM request
            if (!(RAMLESS && slice_mode_e'(hwdata[CTRL_MODE_LSB +: 2]) == MODE_RAM)) begin
                modeR <= slice_mode_e'(hwdata[CTRL_MODE_LSB +: 2]);
            end
            opR <= ripple_op_e'(hwdata[CTRL_OP_LSB +: 4]);
            dualR <= hwdata[CTRL_DUAL_BIT];
            setValR <= {hwdata[CTRL_SET1_BIT], hwdata[CTRL_SET0_BIT]};
        end
    end

    ramless_mode_a: assert property (RAMLESS |-> modeR != MODE_RAM)
        else $error("RAM mode entered on RAM-less variant");

    sequence ctrlWriteAddr;
        takeReq && hwrite && hsize == HSIZE_WORD && haddr == ADDR_CTRL;
    endsequence
    sequence ctrlDataPhase;
        !RAMLESS;
    endsequence
    ctrl_write_lands_a: assert property (ctrlWriteAddr ##1 ctrlDataPhase |=>
        modeR == slice_mode_e'($past(hwdata[CTRL_MODE_LSB +: 2])))
        else $error("Mode not taken from bus write");

    // Only RAM mode opens the fabric write port; ROM contents come over the bus
    assign ramWe = (modeR == MODE_RAM) && clkEnable;

    dist_ram_16x2 tables (
        .clk(clk),
        .rst_n(rst_n),
        .cfgWe0(phaseWrite_r && phaseAddr_r == ADDR_LUT0),
        .cfgWe1(phaseWrite_r && phaseAddr_r == ADDR_LUT1),
        .cfgData(hwdata[15:0]),
        .ramWe(ramWe),
        .waddr(lutInA),
        .wdata(multipurposeIn),
        .raddrA(lutInA),
        .raddrB(lutInB),
        .readA(readA),
        .readB(readB),
        .table0(table0),
        .table1(table1)
    );

    rom_no_write_a: assert property (modeR == MODE_ROM && !phaseWrite_r |=>
        $stable(table0) && $stable(table1))
        else $error("ROM contents changed");

    // Ripple unit: operand A on input 0 of the a- and b-inputs, B on input 1, lutInA[2] chooses add
    assign opA = {lutInB[0], lutInA[0]};
    assign opB = {lutInB[1], lutInA[1]};

    always_comb begin
        aEff = opA;
        bEff = opB;
        isNe = 1'b0;
        unique case (opR)
            OP_ADD: bEff = opB;
            OP_SUB: bEff = ~opB;
            OP_ADDSUB: bEff = lutInA[2] ? opB : ~opB;
            OP_UPCOUNT: begin
                aEff = registerOut_r;
                bEff = 2'h0;
            end
            OP_DOWNCOUNT: begin
                aEff = registerOut_r;
                bEff = 2'h3;
            end
            OP_MULT: aEff = opA & {2{multipurposeIn[0]}};
            OP_GE: bEff = ~opB;
            OP_LE: begin
                aEff = opB;
                bEff = ~opA;
            end
            OP_NE: isNe = 1'b1;
            default: bEff = opB;
        endcase
        gen = aEff & bEff;
        prop = aEff ^ bEff;
        // Not-equal shows the bitwise difference rather than a sum
        rippleSum = isNe ? prop : {prop[1] ^ (gen[0] | (prop[0] & carryChainIn)), prop[0] ^ carryChainIn};
        // Not-equal ORs along the chain instead of carrying
        rippleCarry = isNe ? (carryChainIn | (|(opA ^ opB))) : carry_gp(gen, prop, carryChainIn);
    end

    ripple_add_a: assert property (modeR == MODE_RIPPLE && opR == OP_ADD |->
        {rippleCarry, rippleSum} == 3'({1'b0, opA} + {1'b0, opB} + {2'h0, carryChainIn}))
        else $error("Ripple add wrong");
    ripple_ge_a: assert property (opR == OP_GE && carryChainIn |-> rippleCarry == (opA >= opB))
        else $error("Compare ge wrong");
    carry_chain_a: assert property (modeR == MODE_RIPPLE |-> carryChainOut == rippleCarry)
        else $error("Carry out not from ripple unit");

    // Table outputs and wide muxes per mode
    always_comb begin
        unique case (modeR)
            MODE_LOGIC: bypass = {readB[1], readA[0]};
            MODE_ROM: bypass = {readB[1], readA[0]};
            MODE_RIPPLE: bypass = rippleSum;
            MODE_RAM: bypass = readA;
        endcase
        wide5 = multipurposeIn[0] ? bypass[1] : bypass[0];
        wider = multipurposeIn[1] ? neighbourWide5In : wide5;
        // Paired dual-port use: the companion read port appears on the wide outputs
        if (modeR == MODE_RAM && dualR) begin
            wide5 = readB[0];
            wider = readB[1];
        end
    end

    logic_lookup_a: assert property (modeR == MODE_LOGIC |->
        tableBypassOut == {table1[lutInB], table0[lutInA]})
        else $error("Lookup result wrong");
    wide5_mux_a: assert property (!(modeR == MODE_RAM && dualR) |->
        wide5MuxOut == (multipurposeIn[0] ? tableBypassOut[1] : tableBypassOut[0]))
        else $error("Five-input mux wrong");
    wider_mux_a: assert property (!(modeR == MODE_RAM && dualR) && multipurposeIn[1] |->
        widerMuxOut == neighbourWide5In)
        else $error("Wider mux wrong");
    dual_read_a: assert property (modeR == MODE_RAM && dualR |->
        {widerMuxOut, wide5MuxOut} == {table1[lutInB], table0[lutInB]})
        else $error("Read-only port wrong");

    // Output registers
    assign counting = (modeR == MODE_RIPPLE) && (opR == OP_UPCOUNT || opR == OP_DOWNCOUNT);
    assign qNxt = counting ? rippleSum : bypass;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            registerOut_r <= Q_RESET;
        end else if (localSetReset) begin
            registerOut_r <= setValR;
        end else if (clkEnable) begin
            registerOut_r <= qNxt;
        end
    end

    sequence enabledLoad;
        clkEnable && !localSetReset && !counting;
    endsequence
    reg_capture_a: assert property (enabledLoad |=> registerOut == $past(tableBypassOut))
        else $error("Register missed bypass value");
    reg_hold_a: assert property (!clkEnable && !localSetReset |=> $stable(registerOut))
        else $error("Register moved without enable");
    reg_setreset_a: assert property (localSetReset |=> registerOut == $past(setValR))
        else $error("Set/reset value not forced");
    up_count_a: assert property (modeR == MODE_RIPPLE && opR == OP_UPCOUNT && carryChainIn
        && clkEnable && !localSetReset [*2] |-> registerOut == 2'($past(registerOut) + 2'h1))
        else $error("Counter did not step");

    // Carry passes straight through outside ripple mode so chains stay intact
    assign carryChainOut = (modeR == MODE_RIPPLE) ? rippleCarry : carryChainIn;
    assign tableBypassOut = bypass;
    assign wide5MuxOut = wide5;
    assign widerMuxOut = wider;
    assign registerOut = registerOut_r;
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // Ready rises one edge after reset release, so the first edge is skipped
    bus_ready_a: assert property ($past(rst_n) |-> hreadyout && !hresp)
        else $error("Bus not ready or error response");
endmodule

// ---- tb/neighbour_slice.sv ----
// Behavioural neighbouring slice driving the carry and wide-mux inputs
`timescale 1ns/1ps
module neighbour_slice (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] opA,
    input wire logic [1:0] opB,
    input wire logic wideSel,
    output logic carryOut_r,
    output logic wide5Out_r
);
    logic [2:0] sum;
    assign sum = {1'b0, opA} + {1'b0, opB};
    // Registered, so the slice under test sees its neighbour one edge late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carryOut_r <= 1'b0;
            wide5Out_r <= 1'b0;
        end else begin
            carryOut_r <= sum[2];
            wide5Out_r <= wideSel;
        end
    end
endmodule

// ---- tb/test_fpga_logic_slice.sv ----
// Self-checking bench for the logic slice and its setup port
`timescale 1ns/1ps
module test_fpga_logic_slice
    import slice_pkg::*;
();
    localparam logic [15:0] T0 = 16'hA5C3;
    localparam logic [15:0] T1 = 16'h3C96;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] lutInA = 4'h0;
    logic [3:0] lutInB = 4'h0;
    logic [1:0] multipurposeIn = 2'h0;
    logic clkEnable = 1'b0;
    logic localSetReset = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] nOpA = 2'h0;
    logic [1:0] nOpB = 2'h0;
    logic nWideSel = 1'b0;
    logic carryChainIn, neighbourWide5In, hready, hreadyout, hresp;
    logic wide5MuxOut, widerMuxOut, carryChainOut;
    logic [31:0] hrdata, hrdata2, rd;
    logic [1:0] tableBypassOut, registerOut;
    int miscompares = 0;
    int compares = 0;

    assign hready = hreadyout;
    always #50 clk = ~clk;

    fpga_logic_slice dut (.*);
    // RAM-less variant shares every input and is only read back over the bus
    fpga_logic_slice #(.RAMLESS(1'b1)) dut2 (.*, .hrdata(hrdata2), .hreadyout(), .hresp(),
        .tableBypassOut(), .registerOut(), .wide5MuxOut(), .widerMuxOut(), .carryChainOut());
    neighbour_slice nbr (.clk(clk), .rst_n(rst_n), .opA(nOpA), .opB(nOpB), .wideSel(nWideSel),
        .carryOut_r(carryChainIn), .wide5Out_r(neighbourWide5In));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, expv);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic apply(input logic [3:0] a, input logic [3:0] b, input logic [1:0] m, input logic ce);
        @(posedge clk);
        lutInA <= a;
        lutInB <= b;
        multipurposeIn <= m;
        clkEnable <= ce;
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] mode, input logic [3:0] op, input logic [2:0] ext);
        return {23'h0, ext, op, mode};
    endfunction

    // Returns {carry, sum} of one 2-bit ripple step
    function automatic logic [2:0] ripple(input logic [3:0] op, input logic [1:0] a, input logic [1:0] b,
        input logic c, input logic m0, input logic sel);
        logic [1:0] x;
        logic [1:0] y;
        x = a;
        y = ~b;
        if (op == OP_ADD || op == OP_MULT || (op == OP_ADDSUB && sel)) y = b;
        if (op == OP_MULT) x = a & {2{m0}};
        if (op == OP_LE) begin
            x = b;
            y = ~a;
        end
        if (op == OP_NE) return {c | (a != b), a ^ b};
        return {1'b0, x} + {1'b0, y} + {2'h0, c};
    endfunction

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial begin
        logic [1:0] q;
        logic [1:0] f;
        logic [2:0] e;
        logic w5;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check(registerOut, 2'h0);
        bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b1, ADDR_LUT0, {16'h0, T0});
        bus(1'b1, ADDR_LUT1, {16'h0, T1});
        bus(1'b0, ADDR_LUT1, 32'h0000_0000);
        check(rd, {16'h0, T1});
        for (int i = 0; i < 16; i++) begin
            apply(i[3:0], ~i[3:0], i[1:0], 1'b1);
            nWideSel <= i[3];
            @(posedge clk);
            @(negedge clk);
            f = {T1[~i[3:0]], T0[i[3:0]]};
            w5 = i[0] ? f[1] : f[0];
            check(tableBypassOut, f);
            check(wide5MuxOut, w5);
            check(widerMuxOut, i[1] ? i[3] : w5);
            check(registerOut, f);
            check(carryChainOut, carryChainIn);
        end
        // Inputs now give F of 0, so hold, set and load are all distinct
        bus(1'b1, ADDR_CTRL, ctrl(MODE_LOGIC, 4'h0, 3'h6));
        apply(4'h2, 4'h0, 2'h0, 1'b0);
        @(posedge clk);
        @(negedge clk);
        check(registerOut, 2'h1);
        @(posedge clk);
        clkEnable <= 1'b1;
        localSetReset <= 1'b1;
        @(posedge clk);
        clkEnable <= 1'b0;
        localSetReset <= 1'b0;
        @(negedge clk);
        check(registerOut, 2'h3);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apply(4'h2, 4'h0, 2'h0, 1'b1);
        @(posedge clk);
        @(negedge clk);
        check(registerOut, 2'h0);
        for (int op = 0; op < 9; op++) begin
            if (op == 3 || op == 4) continue;
            bus(1'b1, ADDR_CTRL, ctrl(MODE_RIPPLE, op[3:0], 3'h0));
            for (int c = 0; c < 2; c++) begin
                @(posedge clk);
                nOpA <= 2'h3;
                nOpB <= c[1:0];
                for (int v = 0; v < 64; v++) begin
                    apply({1'b0, v[5], v[2], v[0]}, {2'h0, v[3], v[1]}, {1'b0, v[4]}, 1'b0);
                    @(negedge clk);
                    e = ripple(op[3:0], v[1:0], v[3:2], c[0], v[4], v[5]);
                    if (op == 6 || op == 8) check(carryChainOut, e[2]);
                    else check({carryChainOut, tableBypassOut}, e);
                end
            end
        end
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ADDR_CTRL, ctrl(MODE_RIPPLE, k ? OP_DOWNCOUNT : OP_UPCOUNT, k ? 3'h6 : 3'h0));
            @(posedge clk);
            nOpB <= k ? 2'h0 : 2'h1;
            localSetReset <= 1'b1;
            clkEnable <= 1'b1;
            @(posedge clk);
            localSetReset <= 1'b0;
            q = k ? 2'h3 : 2'h0;
            for (int s = 0; s < 6; s++) begin
                @(negedge clk);
                check(registerOut, q);
                check(carryChainOut, k ? q != 2'h0 : q == 2'h3);
                q = k ? q - 2'h1 : q + 2'h1;
                @(posedge clk);
            end
        end
        bus(1'b1, ADDR_CTRL, ctrl(MODE_RAM, 4'h0, 3'h1));
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0042);
        check(hrdata2, 32'h0000_0041);
        for (int i = 0; i < 16; i++) begin
            apply(i[3:0], 4'h0, i[1:0] ^ i[3:2], 1'b1);
        end
        // Write enable dropped: reads below must not disturb contents
        for (int i = 0; i < 16; i++) begin
            apply(i[3:0], ~i[3:0], 2'h3, 1'b0);
            @(negedge clk);
            check(tableBypassOut, i[1:0] ^ i[3:2]);
            check({widerMuxOut, wide5MuxOut}, ~i[1:0] ^ ~i[3:2]);
        end
        bus(1'b0, ADDR_LUT1, 32'h0000_0000);
        check(rd, 32'h0000_33CC);
        bus(1'b1, ADDR_CTRL, ctrl(MODE_ROM, 4'h0, 3'h0));
        // Write data differs from the stored bits, so a stray write would show
        apply(4'h5, 4'h6, 2'h3, 1'b1);
        @(posedge clk);
        clkEnable <= 1'b0;
        bus(1'b0, ADDR_LUT0, 32'h0000_0000);
        check(rd, 32'h0000_5A5A);
        check(tableBypassOut, 2'h2);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        check(hrdata2, 32'h0000_0003);
        check(rd, 32'h0000_0003);
        check({hreadyout, hresp}, 2'h2);
        final_report();
    end
endmodule
